// [i2cm_bit_engine.sv]
// Bit-level engine: start, stop, one written or read bit on SCL/SDA
`timescale 1ns/1ps
`include "i2cm_map.svh"

module i2cm_bit_engine #(
    parameter int QUARTER_CYC = `I2CM_QUARTER_CYC
) (
    input  wire logic       clk_i,      // 250 MHz clock
    input  wire logic       rst_i,      // Async reset, active high
    input  wire logic       go_i,       // Start a bit command
    input  wire logic [1:0] cmd_i,      // Command code
    input  wire logic       bit_i,      // Bit to write
    output logic            done_o,     // Command finished, one cycle
    output logic            rx_bit_o,   // Sampled SDA bit
    input  wire logic       scl_i,      // SCL pin level
    input  wire logic       sda_i,      // SDA pin level
    output logic            scl_oe_o,   // Pull SCL low
    output logic            sda_oe_o    // Pull SDA low
);

    generate
        if (QUARTER_CYC < 1 || QUARTER_CYC > 65535) begin : g_bad_quarter
            $error("QUARTER_CYC out of range");
        end
    endgenerate

    i2cm_pkg::i2cm_phase_e ph_r, ph_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [1:0]  cmd_r, cmd_nxt;
    logic        bit_r, bit_nxt;
    logic        done_nxt, rx_nxt, scl_oe_nxt, sda_oe_nxt;
    logic [2:0]  scl_s_r, sda_s_r;
    logic        scl_f_r, sda_f_r;

    // Three-stage sampling; a level counts once stages two and three agree
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s_r <= `I2CM_RST_SYNC;
            sda_s_r <= `I2CM_RST_SYNC;
            scl_f_r <= 1'h1;
            sda_f_r <= 1'h1;
        end else begin
            scl_s_r <= {scl_s_r[1:0], scl_i};
            sda_s_r <= {sda_s_r[1:0], sda_i};
            scl_f_r <= (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
            sda_f_r <= (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
        end
    end

    always_comb begin
        ph_nxt     = ph_r;
        cnt_nxt    = cnt_r;
        cmd_nxt    = cmd_r;
        bit_nxt    = bit_r;
        done_nxt   = 1'h0;
        rx_nxt     = rx_bit_o;
        scl_oe_nxt = scl_oe_o;
        sda_oe_nxt = sda_oe_o;
        if (ph_r == i2cm_pkg::I2CM_PH_IDLE) begin
            if (go_i) begin
                ph_nxt  = i2cm_pkg::I2CM_PH_0;
                cnt_nxt = 16'h0000;
                cmd_nxt = cmd_i;
                bit_nxt = bit_i;
            end
        // Phases 1 and 2, with SCL released, hold while a slave stretches the clock
        end else if ((ph_r == i2cm_pkg::I2CM_PH_1 || ph_r == i2cm_pkg::I2CM_PH_2) && !scl_f_r) begin
            cnt_nxt = cnt_r;
        end else if (cnt_r != 16'(QUARTER_CYC - 1)) begin
            cnt_nxt = cnt_r + 16'h0001;
        end else begin
            cnt_nxt = 16'h0000;
            case (ph_r)
                i2cm_pkg::I2CM_PH_0: ph_nxt = i2cm_pkg::I2CM_PH_1;
                i2cm_pkg::I2CM_PH_1: ph_nxt = i2cm_pkg::I2CM_PH_2;
                i2cm_pkg::I2CM_PH_2: begin
                    ph_nxt = i2cm_pkg::I2CM_PH_3;
                    rx_nxt = sda_f_r;
                end
                i2cm_pkg::I2CM_PH_3: begin
                    ph_nxt   = i2cm_pkg::I2CM_PH_IDLE;
                    done_nxt = 1'h1;
                end
                default: ph_nxt = i2cm_pkg::I2CM_PH_IDLE;
            endcase
        end
        // Pin drive follows the phase being entered
        case (ph_nxt)
            i2cm_pkg::I2CM_PH_0: begin
                scl_oe_nxt = (cmd_nxt == i2cm_pkg::I2CM_CMD_STOP) || (cmd_nxt != i2cm_pkg::I2CM_CMD_START) ||
                             scl_oe_o;
                sda_oe_nxt = (cmd_nxt == i2cm_pkg::I2CM_CMD_STOP) ||
                             (cmd_nxt == i2cm_pkg::I2CM_CMD_WR && !bit_nxt);
            end
            i2cm_pkg::I2CM_PH_1: scl_oe_nxt = 1'h0;
            i2cm_pkg::I2CM_PH_2: begin
                if (cmd_r == i2cm_pkg::I2CM_CMD_START) begin
                    sda_oe_nxt = 1'h1;
                end
                if (cmd_r == i2cm_pkg::I2CM_CMD_STOP) begin
                    sda_oe_nxt = 1'h0;
                end
            end
            i2cm_pkg::I2CM_PH_3: scl_oe_nxt = (cmd_r != i2cm_pkg::I2CM_CMD_STOP);
            default: ;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_r     <= i2cm_pkg::I2CM_PH_IDLE;
            cnt_r    <= 16'h0000;
            cmd_r    <= 2'h0;
            bit_r    <= 1'h1;
            done_o   <= 1'h0;
            rx_bit_o <= 1'h1;
            scl_oe_o <= 1'h0;
            sda_oe_o <= 1'h0;
        end else begin
            ph_r     <= ph_nxt;
            cnt_r    <= cnt_nxt;
            cmd_r    <= cmd_nxt;
            bit_r    <= bit_nxt;
            done_o   <= done_nxt;
            rx_bit_o <= rx_nxt;
            scl_oe_o <= scl_oe_nxt;
            sda_oe_o <= sda_oe_nxt;
        end
    end

endmodule : i2cm_bit_engine

// [i2cm_eeprom_model.sv]
// Behavioural serial EEPROM slave on the two-wire bus
`timescale 1ns/1ps

module i2cm_eeprom_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50 // Slave address, arbitrary
) (
    input  wire logic scl_i,    // SCL wire level
    input  wire logic sda_i,    // SDA wire level
    output logic      sda_oe_o  // Pull SDA low
);
    logic [7:0] mem [0:255];
    logic [7:0] sh;
    logic [7:0] ptr;
    int         bitn;
    logic       act;
    logic       sel;
    logic       rd;
    logic       hdr;
    logic       wa;
    logic       tx;
    logic       clk_d;

    initial begin
        sda_oe_o = 1'b0;
        act = 1'b0;
        ptr = 8'h00;
        clk_d = 1'b0;
        sel = 1'b0;
        rd = 1'b0;
    end

    // Start or repeated start restarts the byte framing
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) begin
            act = 1'b1;
            bitn = 0;
            hdr = 1'b1;
            tx = 1'b0;
            clk_d = 1'b0;
            sda_oe_o = 1'b0;
        end
    end

    always @(posedge sda_i) begin
        if (scl_i === 1'b1) act = 1'b0;
    end

    always @(posedge scl_i) begin
        if (act) begin
            clk_d = 1'b1;
            if (bitn < 8 && !tx) sh = {sh[6:0], sda_i};
            if (bitn == 8 && tx && sda_i) sel = 1'b0;
        end
    end

    // Data changes only while SCL is low, so it never fakes a start or stop
    always @(negedge scl_i) begin
        if (act && clk_d) begin
            clk_d = 1'b0;
            bitn = bitn + 1;
            sda_oe_o = 1'b0;
            if (bitn == 8 && !tx) begin
                if (hdr) begin
                    sel = (sh[7:1] == DEV_ADDR);
                    rd = sh[0];
                    wa = 1'b1;
                end else if (sel && wa) begin
                    ptr = sh;
                    wa = 1'b0;
                end else if (sel) begin
                    mem[ptr] = sh;
                    ptr = ptr + 8'h01;
                end
                hdr = 1'b0;
                sda_oe_o = sel;
            end
            if (bitn == 9) begin
                bitn = 0;
                tx = rd && sel;
                if (tx) begin
                    sh = mem[ptr];
                    ptr = ptr + 8'h01;
                end
            end
            if (tx && bitn < 8) sda_oe_o = ~sh[7 - bitn];
        end
    end
endmodule : i2cm_eeprom_model

// [i2cm_map.svh]
// Timing, bit positions and reset values of the byte-oriented I2C master
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH

`define I2CM_CLK_PERIOD_PS   4000
`define I2CM_SCL_PERIOD_NS   10000
`define I2CM_QUARTER_CYC     ((`I2CM_SCL_PERIOD_NS * 1000 + 4 * `I2CM_CLK_PERIOD_PS - 1) / (4 * `I2CM_CLK_PERIOD_PS))
`define I2CM_BYTE_MSB        3'h7
`define I2CM_DIR_BIT         0
`define I2CM_LEVEL_ACK       1'h0
`define I2CM_LEVEL_NACK      1'h1
`define I2CM_RST_DONE        1'h1
`define I2CM_RST_CLEAR       1'h0
`define I2CM_RST_BYTE        8'h00
`define I2CM_RST_CNT         3'h0
`define I2CM_RST_SYNC        3'h7

`endif

// [i2cm_pkg.sv]
// Types shared by the I2C master byte controller and its bit engine
package i2cm_pkg;

    typedef enum logic [1:0] {
        I2CM_CMD_START = 2'h0,
        I2CM_CMD_STOP  = 2'h1,
        I2CM_CMD_WR    = 2'h2,
        I2CM_CMD_RD    = 2'h3
    } i2cm_cmd_e;

    // Gray along idle, ph0, ph1, ph2, ph3
    typedef enum logic [2:0] {
        I2CM_PH_IDLE = 3'h0,
        I2CM_PH_0    = 3'h1,
        I2CM_PH_1    = 3'h3,
        I2CM_PH_2    = 3'h2,
        I2CM_PH_3    = 3'h6
    } i2cm_phase_e;

    // Gray along idle, start, bits, ack, stop
    typedef enum logic [2:0] {
        I2CM_ST_IDLE = 3'h0,
        I2CM_ST_STA  = 3'h1,
        I2CM_ST_BIT  = 3'h3,
        I2CM_ST_ACK  = 3'h2,
        I2CM_ST_STP  = 3'h6
    } i2cm_state_e;

endpackage : i2cm_pkg

// [i2cm_top.sv]
// Byte-oriented I2C master: start, address, page write, sequential read, stop
//
// How it works
// (RL1) Software waits for done before any transfer.
// (RL2) Start request plus write sends start, then byte.
// (RL3) Each accepted data write clears done at once.
// (RL4) Done sets after each byte and its acknowledge bit complete.
// (RL5) Slave acknowledge of last byte is reported.
// (RL6) Software checks done and ack per byte.
// (RL7) Page write bytes follow without any stop.
// (RL8) Slave stores page bytes at successive addresses.
// (RL9) Start with direction one gives repeated start read.
// (RL10) Dummy write in read mode clocks one byte in.
// (RL11) Full byte sets receive flag and data.
// (RL12) Master acknowledge bit acknowledges each received byte.
// (RL13) Slave keeps sending while master acknowledges.
// (RL14) Ack bit cleared before last byte means nack.
// (RL15) Stop request plus write makes stop, then done.
// (RL16) Stop releases the bus ownership.
// (RL17) Sequential read begins by random or current read.
// (RL18) Software aborts with stop after about 1 ms.
// (RL19) Reset leaves bus idle, requests clear, done set.
`timescale 1ns/1ps
`include "i2cm_map.svh"

module i2cm_top #(
    parameter int QUARTER_CYC = `I2CM_QUARTER_CYC
) (
    input  wire logic       clk_i,                  // 250 MHz clock
    input  wire logic       rst_i,                  // Async reset, active high
    input  wire logic       gen_start_request_i,    // Control: start before byte
    input  wire logic       gen_stop_request_i,     // Control: stop on next write
    input  wire logic       controller_enable_bit_i,// Control: controller enable
    input  wire logic       master_ack_request_i,   // Control: ack received bytes
    input  wire logic       tx_wr_i,                // Transmit data write strobe
    input  wire logic [7:0] tx_data_i,              // Transmit data
    input  wire logic       rx_rd_i,                // Receive data read strobe
    output logic            transfer_done_flag_o,   // Status: operation complete
    output logic            slave_ack_flag_o,       // Status: slave acknowledged
    output logic            rx_byte_ready_flag_o,   // Status: byte received
    output logic [7:0]      rx_data_o,              // Receive data
    output logic            bus_owned_o,            // Bus held between start and stop
    input  wire logic       scl_i,                  // SCL pin level
    output logic            scl_o,                  // SCL drive value
    output logic            scl_oe_o,               // SCL drive enable
    input  wire logic       sda_i,                  // SDA pin level
    output logic            sda_o,                  // SDA drive value
    output logic            sda_oe_o                // SDA drive enable
);

    i2cm_pkg::i2cm_state_e st_r, st_nxt;
    logic       done_r, done_nxt;
    logic       sack_r, sack_nxt;
    logic       rxr_r, rxr_nxt;
    logic [7:0] rxd_r, rxd_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic       rdm_r, rdm_nxt;
    logic       rdb_r, rdb_nxt;
    logic       sta_r, sta_nxt;
    logic       stp_r, stp_nxt;
    logic       own_r, own_nxt;
    logic       go_r, go_nxt;
    logic [1:0] cmd_r, cmd_nxt;
    logic       bit_r, bit_nxt;
    logic       eng_done, eng_rx;
    logic       accept;

    // Writes while a byte is on the wire are dropped; software polls done first
    assign accept = tx_wr_i && controller_enable_bit_i && st_r == i2cm_pkg::I2CM_ST_IDLE; // RL1

    i2cm_bit_engine #(
        .QUARTER_CYC (QUARTER_CYC)
    ) u_bit (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .go_i     (go_r),
        .cmd_i    (cmd_r),
        .bit_i    (bit_r),
        .done_o   (eng_done),
        .rx_bit_o (eng_rx),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .scl_oe_o (scl_oe_o),
        .sda_oe_o (sda_oe_o)
    );

    always_comb begin
        st_nxt   = st_r;
        done_nxt = done_r;
        sack_nxt = sack_r;
        rxr_nxt  = rxr_r;
        rxd_nxt  = rxd_r;
        sh_nxt   = sh_r;
        cnt_nxt  = cnt_r;
        rdm_nxt  = rdm_r;
        rdb_nxt  = rdb_r;
        sta_nxt  = sta_r;
        stp_nxt  = stp_r;
        own_nxt  = own_r;
        go_nxt   = 1'h0;
        cmd_nxt  = cmd_r;
        bit_nxt  = bit_r;
        if (rx_rd_i) begin
            rxr_nxt = 1'h0;
        end
        case (st_r)
            i2cm_pkg::I2CM_ST_IDLE: begin
                if (accept) begin
                    done_nxt = 1'h0;                                    // RL3
                    sh_nxt   = tx_data_i;
                    sta_nxt  = gen_start_request_i;
                    stp_nxt  = gen_stop_request_i;
                    cnt_nxt  = `I2CM_BYTE_MSB;
                    go_nxt   = 1'h1;
                    if (gen_stop_request_i) begin
                        st_nxt  = i2cm_pkg::I2CM_ST_STP;                // RL15
                        cmd_nxt = i2cm_pkg::I2CM_CMD_STOP;
                    end else if (gen_start_request_i) begin
                        st_nxt  = i2cm_pkg::I2CM_ST_STA;                // RL2 RL9
                        cmd_nxt = i2cm_pkg::I2CM_CMD_START;
                    end else begin
                        // Plain write: next page byte, or dummy that fetches a read byte
                        st_nxt  = i2cm_pkg::I2CM_ST_BIT;                // RL7 RL10
                        rdb_nxt = rdm_r;
                        cmd_nxt = rdm_r ? i2cm_pkg::I2CM_CMD_RD : i2cm_pkg::I2CM_CMD_WR;
                        bit_nxt = tx_data_i[7];
                    end
                end
            end
            i2cm_pkg::I2CM_ST_STA: begin
                if (eng_done) begin
                    own_nxt = 1'h1;
                    rdm_nxt = sh_r[`I2CM_DIR_BIT];                      // RL9
                    rdb_nxt = 1'h0;
                    st_nxt  = i2cm_pkg::I2CM_ST_BIT;
                    go_nxt  = 1'h1;
                    cmd_nxt = i2cm_pkg::I2CM_CMD_WR;
                    bit_nxt = sh_r[7];
                end
            end
            i2cm_pkg::I2CM_ST_BIT: begin
                if (eng_done) begin
                    sh_nxt = {sh_r[6:0], eng_rx};
                    go_nxt = 1'h1;
                    if (cnt_r != 3'h0) begin
                        cnt_nxt = cnt_r - 3'h1;
                        bit_nxt = sh_r[6];
                    end else begin
                        st_nxt = i2cm_pkg::I2CM_ST_ACK;
                        if (rdb_r) begin
                            // Ack level taken live so software can drop it before the last byte
                            cmd_nxt = i2cm_pkg::I2CM_CMD_WR;
                            bit_nxt = master_ack_request_i ? `I2CM_LEVEL_ACK : `I2CM_LEVEL_NACK; // RL12 RL14
                            rxd_nxt = {sh_r[6:0], eng_rx};
                            rxr_nxt = 1'h1;                             // RL11
                        end else begin
                            cmd_nxt = i2cm_pkg::I2CM_CMD_RD;
                            bit_nxt = `I2CM_LEVEL_NACK;
                        end
                    end
                end
            end
            i2cm_pkg::I2CM_ST_ACK: begin
                if (eng_done) begin
                    st_nxt   = i2cm_pkg::I2CM_ST_IDLE;
                    done_nxt = 1'h1;                                    // RL4
                    if (!rdb_r) begin
                        sack_nxt = (eng_rx == `I2CM_LEVEL_ACK);         // RL5
                    end
                end
            end
            i2cm_pkg::I2CM_ST_STP: begin
                if (eng_done) begin
                    st_nxt   = i2cm_pkg::I2CM_ST_IDLE;
                    done_nxt = 1'h1;                                    // RL15
                    own_nxt  = 1'h0;                                    // RL16
                    rdm_nxt  = 1'h0;
                    sta_nxt  = 1'h0;
                    stp_nxt  = 1'h0;
                end
            end
            default: st_nxt = i2cm_pkg::I2CM_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r   <= i2cm_pkg::I2CM_ST_IDLE;                           // RL19
            done_r <= `I2CM_RST_DONE;                                   // RL19
            sack_r <= `I2CM_RST_CLEAR;
            rxr_r  <= `I2CM_RST_CLEAR;
            rxd_r  <= `I2CM_RST_BYTE;
            sh_r   <= `I2CM_RST_BYTE;
            cnt_r  <= `I2CM_RST_CNT;
            rdm_r  <= `I2CM_RST_CLEAR;
            rdb_r  <= `I2CM_RST_CLEAR;
            sta_r  <= `I2CM_RST_CLEAR;                                  // RL19
            stp_r  <= `I2CM_RST_CLEAR;                                  // RL19
            own_r  <= `I2CM_RST_CLEAR;
            go_r   <= `I2CM_RST_CLEAR;
            cmd_r  <= 2'h0;
            bit_r  <= 1'h1;
            scl_o  <= 1'h0;
            sda_o  <= 1'h0;
        end else begin
            st_r   <= st_nxt;
            done_r <= done_nxt;
            sack_r <= sack_nxt;
            rxr_r  <= rxr_nxt;
            rxd_r  <= rxd_nxt;
            sh_r   <= sh_nxt;
            cnt_r  <= cnt_nxt;
            rdm_r  <= rdm_nxt;
            rdb_r  <= rdb_nxt;
            sta_r  <= sta_nxt;
            stp_r  <= stp_nxt;
            own_r  <= own_nxt;
            go_r   <= go_nxt;
            cmd_r  <= cmd_nxt;
            bit_r  <= bit_nxt;
            scl_o  <= 1'h0;
            sda_o  <= 1'h0;
        end
    end

    assign transfer_done_flag_o = done_r;
    assign slave_ack_flag_o     = sack_r;
    assign rx_byte_ready_flag_o = rxr_r;
    assign rx_data_o            = rxd_r;
    assign bus_owned_o          = own_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_wr_clears_done: assert property (accept |=> !done_r) // RL3
        else $error("done not cleared by write");
    a_start_first: assert property (accept && !gen_stop_request_i && gen_start_request_i
        |=> st_r == i2cm_pkg::I2CM_ST_STA && go_r && cmd_r == i2cm_pkg::I2CM_CMD_START) // RL2
        else $error("start not issued first");
    a_page_no_stop: assert property (accept && !gen_stop_request_i && !gen_start_request_i
        |=> st_r == i2cm_pkg::I2CM_ST_BIT && cmd_r != i2cm_pkg::I2CM_CMD_STOP) // RL7
        else $error("stop inserted in page write");
    a_done_after_ack: assert property (st_r == i2cm_pkg::I2CM_ST_ACK && eng_done
        |=> done_r && st_r == i2cm_pkg::I2CM_ST_IDLE) // RL4
        else $error("done missing after byte");
    a_slave_ack_flag: assert property (st_r == i2cm_pkg::I2CM_ST_ACK && eng_done && !rdb_r
        |=> sack_r == !$past(eng_rx)) // RL5
        else $error("slave ack flag wrong");
    a_read_dir_mode: assert property (st_r == i2cm_pkg::I2CM_ST_STA && eng_done
        |=> rdm_r == $past(sh_r[0])) // RL9
        else $error("read mode not taken from direction bit");
    a_rx_flag_data: assert property ($rose(rxr_r) |-> rxd_r == $past(sh_nxt) && st_r == i2cm_pkg::I2CM_ST_ACK) // RL11
        else $error("receive flag without byte");
    a_master_ack_lvl: assert property (st_r == i2cm_pkg::I2CM_ST_BIT && rdb_r && eng_done && cnt_r == 3'h0
        |=> bit_r == !$past(master_ack_request_i) && cmd_r == i2cm_pkg::I2CM_CMD_WR) // RL12 RL14
        else $error("master ack level wrong");
    a_dummy_reads: assert property (accept && rdm_r && !gen_stop_request_i && !gen_start_request_i
        |=> cmd_r == i2cm_pkg::I2CM_CMD_RD && rdb_r) // RL10
        else $error("dummy write did not read");
    a_stop_release: assert property (st_r == i2cm_pkg::I2CM_ST_STP && eng_done
        |=> done_r && !own_r ##[1:8] !scl_oe_o && !sda_oe_o) // RL15 RL16
        else $error("stop did not release bus");

    c_page_write: cover property (accept && !rdm_r && !gen_start_request_i && !gen_stop_request_i);
    c_read_ack: cover property ($rose(rxr_r) && master_ack_request_i);
    c_read_nack: cover property ($rose(rxr_r) && !master_ack_request_i);
    c_stop_done: cover property (st_r == i2cm_pkg::I2CM_ST_STP ##1 st_r == i2cm_pkg::I2CM_ST_IDLE);

endmodule : i2cm_top

// [testbench.sv]
// Self-checking bench: page write, sequential and current reads, refusal, reset
`timescale 1ns/1ps

module testbench;
    typedef struct packed {
        logic       st;
        logic       sp;
        logic       mk;
        logic [2:0] pad;
        logic [7:0] d;
        logic       ak;
        logic       rx;
    } i2cm_row_s;

    localparam int NR = 25;
    logic       clk, rst, start_req, stop_req, enable, mack, tx_wr, rx_rd;
    logic [7:0] tx_data, rx_data;
    logic       done, sack, rxr, owned, scl_oe, sda_oe, slv_oe;
    wire        scl_w = ~scl_oe;
    wire        sda_w = ~(sda_oe | slv_oe);
    int         n_tests = 0;
    int         n_mismatch = 0;
    // Fields: start, stop, master ack, data or expected byte, expected ack, read row
    i2cm_row_s  rows [NR] = '{
        {6'h20, 8'ha0, 2'h2}, {6'h00, 8'h10, 2'h2}, {6'h00, 8'h3c, 2'h2}, {6'h00, 8'hc3, 2'h2},
        {6'h00, 8'h5a, 2'h2}, {6'h10, 8'h00, 2'h0}, {6'h20, 8'ha0, 2'h2}, {6'h00, 8'h10, 2'h2},
        {6'h28, 8'ha1, 2'h2}, {6'h08, 8'h3c, 2'h1}, {6'h08, 8'hc3, 2'h1}, {6'h00, 8'h5a, 2'h1},
        {6'h10, 8'h00, 2'h0}, {6'h20, 8'hb0, 2'h0}, {6'h10, 8'h00, 2'h0}, {6'h20, 8'ha0, 2'h2},
        {6'h00, 8'hff, 2'h2}, {6'h00, 8'h96, 2'h2}, {6'h10, 8'h00, 2'h0}, {6'h20, 8'ha0, 2'h2},
        {6'h00, 8'hff, 2'h2}, {6'h10, 8'h00, 2'h0}, {6'h20, 8'ha1, 2'h2}, {6'h00, 8'h96, 2'h1},
        {6'h10, 8'h00, 2'h0}};

    i2cm_top #(.QUARTER_CYC(5)) dut (
        .clk_i(clk), .rst_i(rst), .gen_start_request_i(start_req), .gen_stop_request_i(stop_req),
        .controller_enable_bit_i(enable), .master_ack_request_i(mack), .tx_wr_i(tx_wr),
        .tx_data_i(tx_data), .rx_rd_i(rx_rd), .transfer_done_flag_o(done), .slave_ack_flag_o(sack),
        .rx_byte_ready_flag_o(rxr), .rx_data_o(rx_data), .bus_owned_o(owned), .scl_i(scl_w),
        .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe));

    i2cm_eeprom_model slave (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(slv_oe));

    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic idle_check();
        chk(done === 1'b1 && owned === 1'b0 && sack === 1'b0 && rxr === 1'b0, "flags not idle");
        chk(scl_oe === 1'b0 && sda_oe === 1'b0 && rx_data === 8'h00, "bus not released");
    endtask : idle_check

    task automatic pulse_wr(input i2cm_row_s r, input logic en);
        @(posedge clk);
        start_req <= r.st;
        stop_req <= r.sp;
        mack <= r.mk;
        enable <= en;
        tx_data <= r.d;
        tx_wr <= 1'b1;
        @(posedge clk);
        tx_wr <= 1'b0;
    endtask : pulse_wr

    task automatic run_row(input i2cm_row_s r);
        int n;
        n = 0;
        pulse_wr(r, 1'b1);
        @(posedge clk);
        #1;
        chk(done === 1'b0, "done not cleared by write");
        while (done !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk(done === 1'b1, "operation never completed");
        if (!r.sp && !r.rx) chk(sack === r.ak, "slave ack flag wrong");
        chk(owned === !r.sp, "bus ownership wrong");
        if (r.sp) chk(scl_oe === 1'b0 && sda_oe === 1'b0, "bus held after stop");
        if (r.rx) begin
            chk(rxr === 1'b1 && rx_data === r.d, "received byte wrong");
            @(posedge clk);
            rx_rd <= 1'b1;
            @(posedge clk);
            rx_rd <= 1'b0;
            #1;
            chk(rxr === 1'b0, "receive flag not cleared by read");
        end
    endtask : run_row

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Longest path is about 30 operations of roughly 250 cycles each
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        {start_req, stop_req, enable, mack, tx_wr, rx_rd} = 6'h00;
        tx_data = 8'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        idle_check();
        for (int i = 0; i < NR; i++) begin
            run_row(rows[i]);
            if (i == 11) chk(slave.sel === 1'b0, "final read byte was acknowledged");
        end
        // Write with the controller disabled is dropped
        pulse_wr(rows[0], 1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk(done === 1'b1 && scl_oe === 1'b0 && sda_oe === 1'b0, "disabled write acted");
        // Reset in mid-byte, then a clean transfer
        pulse_wr(rows[0], 1'b1);
        repeat (60) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        idle_check();
        rst <= 1'b0;
        run_row(rows[0]);
        run_row(rows[5]);
        end_of_test();
    end
endmodule : testbench
